// ==== common/pusq_pkg.sv ====
package pusq_pkg;
  localparam int PUSQ_SLOTS = 6;
  localparam int PUSQ_DLY_W = 16;
  // default slot delay and crash minimum delay, in ref_clk cycles
  localparam logic [15:0] PUSQ_DLY_DEF = 16'h0010;
  localparam logic [15:0] PUSQ_MIN_DLY = 16'h0004;
  localparam logic [5:0] PUSQ_EN_RST = 6'h00;

  typedef enum logic [5:0] {
    PUSQ_MS_OTHER = 6'h01,
    PUSQ_MS_READY = 6'h02,
    PUSQ_MS_SEQDN = 6'h04
  } pusq_main_e;

  typedef enum logic [4:0] {
    PUSQ_IDLE = 5'h01,
    PUSQ_UP = 5'h02,
    PUSQ_FULL = 5'h04,
    PUSQ_DOWN = 5'h08,
    PUSQ_CRASH = 5'h10
  } pusq_state_e;

  // reasons for leaving ready into sequence-down
  typedef struct packed {
    logic chip_select_lost;
    logic over_temp;
    logic crash_req;
    logic undervoltage_lockout_fault;
    logic soft_reset_req;
  } pusq_fault_s;

  typedef struct packed {
    logic trig_up;
    logic trig_down;
    logic trig_crash;
    logic [5:0] down_en;
  } pusq_matrix_s;
endpackage

// ==== verilog/pusq_slot_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module pusq_slot_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic busy_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= (count == '0) ? W'(1) : count;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg == W'(1)) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/pusq_sequencer.sv ====
// Summary of operation
// - Six slot enables sequenced up and down.
// - Active only in ready or sequence-down.
// - Faults raise seq_down_req to ask main for sequence-down.
// - Trigger-up and trigger-down start separate sequences.
// - Up honoured idle only, down full only.
// - Simultaneous up and down blocks power-up.
// - Down during power-up waits until full.
// - Power-down steps slots highest to lowest.
// - Crash from main sequence-down or crash input.
// - Crash input polarity set by OTP.
// - Crash slots timed by minimum delay only.
// - Crash ignores per-slot down enables.
`timescale 1ns/10ps
`default_nettype none
module pusq_sequencer #(
  parameter int SLOTS = 6,
  parameter int DW = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire pusq_pkg::pusq_main_e main_state,
  input wire pusq_pkg::pusq_fault_s faults,
  input wire pusq_pkg::pusq_matrix_s matrix,
  input wire logic otp_crash_active_low,
  input wire logic [SLOTS*DW-1:0] up_delay,
  input wire logic [SLOTS*DW-1:0] down_delay,
  output logic [SLOTS-1:0] res_en,
  output logic seq_down_req,
  output logic crash_active
);
  import pusq_pkg::*;

  // elaboration checks: the slot index is three bits wide and the
  // package default delays are PUSQ_DLY_W bits wide
  if (SLOTS != PUSQ_SLOTS) begin : g_bad_slots
    $error("slot count must match the package");
  end

  if (SLOTS > 8) begin : g_bad_index
    $error("slot count exceeds the slot index range");
  end

  if (DW < 2 || DW > PUSQ_DLY_W) begin : g_bad_width
    $error("delay width out of range");
  end

  pusq_state_e state_reg;
  logic [2:0] slot_reg;
  logic tmr_start_reg;
  logic tmr_done;
  logic [DW-1:0] tmr_count;
  logic enabled;
  logic crash_in;
  logic [SLOTS-1:0] en_reg;
  logic [DW-1:0] up_dly [SLOTS];
  logic [DW-1:0] down_dly [SLOTS];
  logic crash_go;
  logic set_slot;
  logic clr_slot;

  // unpack the flat delay buses into one word per slot
  for (genvar s = 0; s < SLOTS; s++) begin : g_dly
    assign up_dly[s] = up_delay[s*DW +: DW];
    assign down_dly[s] = down_delay[s*DW +: DW];
  end

  // idle is never crashed: nothing is powered there
  assign crash_go = (crash_in || main_state == PUSQ_MS_SEQDN) &&
                    state_reg != PUSQ_CRASH &&
                    state_reg != PUSQ_IDLE;

  assign enabled = (main_state == PUSQ_MS_READY) ||
                   (main_state == PUSQ_MS_SEQDN);
  assign crash_in = matrix.trig_crash ^ otp_crash_active_low;

  // per-slot delay select; crash uses minimum delay alone
  always_comb begin
    tmr_count = PUSQ_DLY_DEF[DW-1:0];
    case (state_reg)
      PUSQ_UP: tmr_count = up_dly[slot_reg];
      PUSQ_DOWN: tmr_count = down_dly[slot_reg];
      PUSQ_CRASH: tmr_count = PUSQ_MIN_DLY[DW-1:0];
      default: tmr_count = PUSQ_DLY_DEF[DW-1:0];
    endcase
  end

  pusq_slot_timer #(.W(DW)) u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(tmr_start_reg),
    .count(tmr_count),
    .done(tmr_done)
  );

  // main state machine sequence-down request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seq_down_req <= 1'b0;
    end else begin
      seq_down_req <= |faults;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= PUSQ_IDLE;
      slot_reg <= 3'h0;
      tmr_start_reg <= 1'b0;
    end else begin
      tmr_start_reg <= 1'b0;
      if (!enabled) begin
        state_reg <= PUSQ_IDLE;
        slot_reg <= 3'h0;
      end else if (crash_go) begin
        state_reg <= PUSQ_CRASH;
        slot_reg <= 3'(SLOTS - 1);
        tmr_start_reg <= 1'b1;
      end else begin
        case (state_reg)
          PUSQ_IDLE: begin
            if (matrix.trig_up && !matrix.trig_down &&
                main_state == PUSQ_MS_READY) begin
              state_reg <= PUSQ_UP;
              slot_reg <= 3'h0;
              tmr_start_reg <= 1'b1;
            end
          end
          PUSQ_UP: begin
            if (tmr_done) begin
              if (slot_reg == 3'(SLOTS - 1)) begin
                state_reg <= PUSQ_FULL;
              end else begin
                slot_reg <= slot_reg + 3'h1;
                tmr_start_reg <= 1'b1;
              end
            end
          end
          PUSQ_FULL: begin
            if (matrix.trig_down) begin
              state_reg <= PUSQ_DOWN;
              slot_reg <= 3'(SLOTS - 1);
              tmr_start_reg <= 1'b1;
            end
          end
          PUSQ_DOWN, PUSQ_CRASH: begin
            if (tmr_done) begin
              // normal down needs slot's matrix enable; crash ignores it
              if (state_reg == PUSQ_CRASH ||
                  matrix.down_en[slot_reg]) begin
                if (slot_reg == 3'h0) begin
                  state_reg <= PUSQ_IDLE;
                end else begin
                  slot_reg <= slot_reg - 3'h1;
                  tmr_start_reg <= 1'b1;
                end
              end else begin
                tmr_start_reg <= 1'b1;
              end
            end
          end
          default: begin
            state_reg <= PUSQ_IDLE;
          end
        endcase
      end
    end
  end

  // slot enable strobes, qualified exactly like the state machine steps
  assign set_slot = enabled && !crash_go && tmr_done &&
                    state_reg == PUSQ_UP;
  assign clr_slot = enabled && !crash_go && tmr_done &&
                    (state_reg == PUSQ_CRASH ||
                     (state_reg == PUSQ_DOWN &&
                      matrix.down_en[slot_reg]));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      en_reg <= PUSQ_EN_RST;
    end else if (!enabled) begin
      en_reg <= PUSQ_EN_RST;
    end else if (set_slot) begin
      en_reg[slot_reg] <= 1'b1;
    end else if (clr_slot) begin
      en_reg[slot_reg] <= 1'b0;
    end
  end

  // each slot output follows its enable only while the sequencer is enabled
  for (genvar s = 0; s < SLOTS; s++) begin : g_out
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        res_en[s] <= PUSQ_EN_RST[s];
      end else begin
        res_en[s] <= enabled ? en_reg[s] : PUSQ_EN_RST[s];
      end
    end
  end

  // crash flag drops together with the outputs when disabled
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      crash_active <= 1'b0;
    end else begin
      crash_active <= enabled && (state_reg == PUSQ_CRASH);
    end
  end
endmodule
`default_nettype wire

// ==== dv/pusq_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module pusq_asserts #(
  parameter int SLOTS = 6
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire pusq_pkg::pusq_main_e main_state,
  input wire pusq_pkg::pusq_fault_s faults,
  input wire pusq_pkg::pusq_matrix_s matrix,
  input wire logic otp_crash_active_low,
  input wire logic [SLOTS-1:0] res_en,
  input wire logic seq_down_req,
  input wire logic crash_active
);
  import pusq_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic cr_in = matrix.trig_crash ^ otp_crash_active_low;
  wire logic full = res_en == 6'h3F;
  off_idle_a: assert property (main_state == PUSQ_MS_OTHER |=>
    res_en == 6'h00 && !crash_active) else $error("enable while disabled");
  thermo_fill_a: assert property (res_en inside {6'h00, 6'h01, 6'h03,
    6'h07, 6'h0F, 6'h1F, 6'h3F}) else $error("slot order broken");
  one_step_a: assert property ($changed(res_en) |-> res_en == 6'h00 ||
    $countones(res_en ^ $past(res_en)) == 1) else $error("two slots at once");
  full_hold_a: assert property (full && main_state == PUSQ_MS_READY &&
    !matrix.trig_down && !cr_in && !crash_active |=> full)
    else $error("left full unasked");
  crash_in_a: assert property (main_state == PUSQ_MS_READY && full && cr_in
    |-> ##[1:3] crash_active) else $error("crash input missed");
  crash_main_a: assert property (main_state == PUSQ_MS_SEQDN && full
    |-> ##[1:3] crash_active) else $error("main crash missed");
  crash_gap_a: assert property (crash_active && $changed(res_en)
    |=> $stable(res_en)[*3]) else $error("crash step too fast");
  crash_pace_a: assert property (crash_active && $changed(res_en) &&
    res_en != 6'h00 |-> ##[4:16] $changed(res_en)) else $error("crash stalled");
  down_req_a: assert property (seq_down_req == $past(|faults))
    else $error("down request wrong");
  cover property (full);
  cover property ($fell(crash_active));
  cover property (seq_down_req);
endmodule
bind pusq_sequencer pusq_asserts #(.SLOTS(SLOTS)) i_chk (.ref_clk, .reset,
  .main_state, .faults, .matrix, .otp_crash_active_low, .res_en,
  .seq_down_req, .crash_active);
`default_nettype wire

// ==== dv/pusq_matrix_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pusq_matrix_model (
  input wire logic ref_clk,
  input wire logic [3:0] cmd,
  input wire logic otp,
  output var pusq_pkg::pusq_matrix_s matrix
);
  import pusq_pkg::*;
  initial matrix = 9'h000;
  // cmd: up, down, crash, down enables; crash line idles inactive
  always @(posedge ref_clk) begin
    matrix <= #1 {cmd[3], cmd[2], cmd[1] ^ otp, {6{cmd[0]}}};
  end
endmodule
`default_nettype wire

// ==== dv/power_up_down_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module power_up_down_sequencer_tb;
  import pusq_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, otp = 1'b0;
  logic [3:0] cmd = 4'h0;
  pusq_main_e main_state = PUSQ_MS_READY;
  pusq_fault_s faults = 5'h00;
  pusq_matrix_s matrix;
  logic [5:0] res_en;
  logic seq_down_req, crash_active;
  int fails = 0, n_compared = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  pusq_matrix_model i_mdl (.ref_clk, .cmd, .otp, .matrix);
  pusq_sequencer #(.SLOTS(6), .DW(16)) i_dut (.ref_clk, .reset, .main_state,
    .faults, .matrix, .otp_crash_active_low(otp), .up_delay({6{16'h0002}}),
    .down_delay({6{16'h0040}}), .res_en, .seq_down_req, .crash_active);
  task automatic finish_test();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 20000) begin
    fails++;
    finish_test();
  end
  task automatic go(logic [3:0] c);
    @(posedge ref_clk);
    #1 cmd = c;
  endtask
  task automatic wait_en(logic [5:0] v);
    for (int i = 0; i < 2000 && res_en !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK(res_en, v)
  endtask
  task automatic t_updown();
    go(4'h8);
    wait_en(6'h3F);
    go(4'h5);
    wait_en(6'h00);
  endtask
  task automatic t_both();
    go(4'hD);
    repeat (40) @(posedge ref_clk);
    #1 `CHK(res_en, 6'h00)
    go(4'h1);
  endtask
  task automatic t_dnup();
    go(4'h8);
    wait_en(6'h01);
    go(4'h5);
    wait_en(6'h3F);
    wait_en(6'h00);
  endtask
  // crash input exercised active low first, then active high
  task automatic t_crash();
    for (int p = 1; p >= 0; p--) begin
      otp = p[0];
      go(4'h8);
      wait_en(6'h3F);
      go(4'h2);
      repeat (4) @(posedge ref_clk);
      #1 `CHK(crash_active, 1'b1)
      wait_en(6'h00);
      go(4'h0);
    end
  endtask
  task automatic t_main();
    go(4'h8);
    wait_en(6'h3F);
    faults.over_temp = 1'b1;
    main_state = PUSQ_MS_SEQDN;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(seq_down_req, 1'b1)
    wait_en(6'h00);
    main_state = PUSQ_MS_OTHER;
    faults = 5'h00;
    repeat (40) @(posedge ref_clk);
    #1 `CHK(res_en, 6'h00)
    main_state = PUSQ_MS_READY;
    wait_en(6'h07);
    @(posedge ref_clk);
    #1 main_state = PUSQ_MS_OTHER;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(res_en, 6'h00)
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_updown();
    t_both();
    t_dnup();
    t_crash();
    t_main();
    finish_test();
  end
endmodule
`default_nettype wire
